// [rtl/cca_top.sv]
// Capture/compare array: register port, shared counter, flags, module array
`timescale 1ns/1ps
module cca_top #(
    parameter int NUM_MODULES = cca_pkg::MAX_MODULES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [cca_pkg::BYTE_W-1:0] sfr_wdata_i,
    output logic [cca_pkg::BYTE_W-1:0] sfr_rdata_o,
    input wire logic global_interrupt_enable_i,
    input wire logic array_interrupt_enable_i,
    input wire logic counter_irq_enable_i,
    input wire logic [NUM_MODULES-1:0] module_pin_i,
    output logic [NUM_MODULES-1:0] module_pin_o,
    output logic [NUM_MODULES-1:0] module_pin_oe_o,
    output logic irq_o
);
    import cca_pkg::*;

    // The control register has room for six module flags only
    generate
        if (NUM_MODULES < 1 || NUM_MODULES > MAX_MODULES) begin : g_bad
            $error("NUM_MODULES must be 1 to 6");
        end
        // Counter and value registers are moved as exactly two bytes
        if (CNT_W != 2 * BYTE_W) begin : g_bad_width
            $error("Counter must be two bytes wide");
        end
        // Module flags must stay below the run bit of the control register
        if (MAX_MODULES > CTRL_RUN_BIT) begin : g_bad_flags
            $error("Too many module flags for the control register");
        end
    endgenerate

    logic [15:0] count_reg;
    logic run_reg;
    logic wrap_flag_reg;
    logic [NUM_MODULES-1:0] mod_flag_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;
    logic [NUM_MODULES-1:0] sync1_reg;
    logic [NUM_MODULES-1:0] sync2_reg;

    logic ctrl_wr;
    logic cnt_lo_wr;
    logic cnt_hi_wr;
    logic wrap_set;
    logic [NUM_MODULES-1:0] mode_wr;
    logic [NUM_MODULES-1:0] val_lo_wr;
    logic [NUM_MODULES-1:0] val_hi_wr;
    logic [NUM_MODULES-1:0] mod_event;
    logic [NUM_MODULES-1:0] mod_irq_en;
    logic [7:0] mode_rd [NUM_MODULES];
    logic [15:0] value_rd [NUM_MODULES];
    logic [7:0] rdata_next;
    logic [7:0] ctrl_view;
    logic irq_next;
    logic [NUM_MODULES-1:0] mode_hit;
    logic [NUM_MODULES-1:0] val_lo_hit;
    logic [NUM_MODULES-1:0] val_hi_hit;
    logic [NUM_MODULES-1:0] mod_req;
    logic [7:0] mod_rdata [NUM_MODULES];
    logic [7:0] rd_chain [NUM_MODULES+1];
    logic [7:0] rdata_base;

    assign ctrl_wr = sfr_wr_i && (sfr_addr_i == ADDR_CTRL);
    assign cnt_lo_wr = sfr_wr_i && (sfr_addr_i == ADDR_CNT_LO);
    assign cnt_hi_wr = sfr_wr_i && (sfr_addr_i == ADDR_CNT_HI);

    // Pins come from outside the clock domain; two flops before any use
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= module_pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    generate
        for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
            assign mode_hit[g] = (sfr_addr_i == ADDR_MODE_BASE + 8'(g));
            assign val_lo_hit[g] = (sfr_addr_i == ADDR_VAL_BASE + 8'(2 * g));
            assign val_hi_hit[g] = (sfr_addr_i == ADDR_VAL_BASE + 8'(2 * g + 1));
            assign mode_wr[g] = sfr_wr_i && mode_hit[g];
            assign val_lo_wr[g] = sfr_wr_i && val_lo_hit[g];
            assign val_hi_wr[g] = sfr_wr_i && val_hi_hit[g];
            assign mod_irq_en[g] = mode_rd[g][MODE_IRQ_BIT];

            cca_channel u_channel (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .mode_wr_i(mode_wr[g]),
                .val_lo_wr_i(val_lo_wr[g]),
                .val_hi_wr_i(val_hi_wr[g]),
                .wdata_i(sfr_wdata_i),
                .count_i(count_reg),
                .pin_level_i(sync2_reg[g]),
                .mode_o(mode_rd[g]),
                .value_o(value_rd[g]),
                .event_o(mod_event[g]),
                .pin_o(module_pin_o[g]),
                .pin_oe_o(module_pin_oe_o[g])
            );

            // A flag event in the same cycle as a software clear survives
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    mod_flag_reg[g] <= CTRL_RESET[g];
                end else if (mod_event[g]) begin
                    mod_flag_reg[g] <= 1'b1;
                end else if (ctrl_wr) begin
                    mod_flag_reg[g] <= sfr_wdata_i[g];
                end
            end

            // Module bytes for the read port; module addresses never overlap
            always_comb begin
                mod_rdata[g] = mode_rd[g];
                if (val_lo_hit[g]) begin
                    mod_rdata[g] = value_rd[g][7:0];
                end else if (val_hi_hit[g]) begin
                    mod_rdata[g] = value_rd[g][15:8];
                end
            end

            assign rd_chain[g + 1] = (mode_hit[g] || val_lo_hit[g] || val_hi_hit[g])
                ? mod_rdata[g] : rd_chain[g];
            assign mod_req[g] = mod_flag_reg[g] && mod_irq_en[g];
        end
    endgenerate

    // Shared counter; software may load either byte at any time
    assign wrap_set = run_reg && (count_reg == CNT_LAST);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_reg <= CNT_RESET;
        end else if (cnt_lo_wr) begin
            count_reg[7:0] <= sfr_wdata_i;
        end else if (cnt_hi_wr) begin
            count_reg[15:8] <= sfr_wdata_i;
        end else if (run_reg) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_reg <= CTRL_RESET[CTRL_RUN_BIT];
        end else if (ctrl_wr) begin
            run_reg <= sfr_wdata_i[CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wrap_flag_reg <= CTRL_RESET[CTRL_WRAP_BIT];
        end else if (wrap_set) begin
            wrap_flag_reg <= 1'b1;
        end else if (ctrl_wr) begin
            wrap_flag_reg <= sfr_wdata_i[CTRL_WRAP_BIT];
        end
    end

    // Control/status view; unused module flag positions read zero
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[CTRL_WRAP_BIT] = wrap_flag_reg;
        ctrl_view[CTRL_RUN_BIT] = run_reg;
        ctrl_view[NUM_MODULES-1:0] = mod_flag_reg;
    end

    // Read mux; the answer is registered, so it appears one edge after the strobe
    always_comb begin
        rdata_base = RDATA_UNMAPPED;
        if (sfr_addr_i == ADDR_CTRL) begin
            rdata_base = ctrl_view;
        end else if (sfr_addr_i == ADDR_CNT_LO) begin
            rdata_base = count_reg[7:0];
        end else if (sfr_addr_i == ADDR_CNT_HI) begin
            rdata_base = count_reg[15:8];
        end
    end

    // Module bytes override the shared registers along the chain
    assign rd_chain[0] = rdata_base;
    assign rdata_next = rd_chain[NUM_MODULES];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= RDATA_UNMAPPED;
        end else if (sfr_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // Interrupt request; the enables are CPU registers on this clock
    always_comb begin
        irq_next = 1'b0;
        if (global_interrupt_enable_i && array_interrupt_enable_i) begin
            irq_next = (|mod_req)
                || (wrap_flag_reg && counter_irq_enable_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign irq_o = irq_reg;
endmodule

// [include/cca_pkg.sv]
// Shared constants and types of the capture/compare array
package cca_pkg;
    localparam int MAX_MODULES = 6;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 16;
    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MODE_BASE = 8'h01;
    localparam logic [7:0] ADDR_CNT_LO = 8'h07;
    localparam logic [7:0] ADDR_CNT_HI = 8'h08;
    localparam logic [7:0] ADDR_VAL_BASE = 8'h09;
    // Control/status fields
    localparam int CTRL_WRAP_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    // Mode register fields
    localparam int MODE_WIDE_BIT = 7;
    localparam int MODE_CMP_BIT = 6;
    localparam int MODE_RISE_BIT = 5;
    localparam int MODE_FALL_BIT = 4;
    localparam int MODE_EQ_BIT = 3;
    localparam int MODE_FLIP_BIT = 2;
    localparam int MODE_PWM_BIT = 1;
    localparam int MODE_IRQ_BIT = 0;
    // Reset values and the last counter value
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [15:0] CNT_LAST = 16'hFFFF;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    typedef enum logic [6:0] {
        CCA_OFF = 7'h01,
        CCA_CAPT = 7'h02,
        CCA_TIMER = 7'h04,
        CCA_HSO = 7'h08,
        CCA_FREQ = 7'h10,
        CCA_PWM8 = 7'h20,
        CCA_WIDE_MODULATOR_SELECT = 7'h40
    } cca_mode_type;
endpackage

// [rtl/cca_channel.sv]
// One capture/compare module: mode decode, value register, pin logic
`timescale 1ns/1ps
module cca_channel (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_wr_i,
    input wire logic val_lo_wr_i,
    input wire logic val_hi_wr_i,
    input wire logic [cca_pkg::BYTE_W-1:0] wdata_i,
    input wire logic [cca_pkg::CNT_W-1:0] count_i,
    input wire logic pin_level_i,
    output logic [cca_pkg::BYTE_W-1:0] mode_o,
    output logic [cca_pkg::CNT_W-1:0] value_o,
    output logic event_o,
    output logic pin_o,
    output logic pin_oe_o
);
    import cca_pkg::*;

    logic [7:0] mode_reg;
    logic [15:0] value_reg;
    logic prev_reg;
    logic event_reg;
    logic pin_reg;
    logic oe_reg;
    cca_mode_type sel;
    logic rise, fall, cap_hit, match16, match8, cmp_hit;

    // Decode of the mode bits; any other combination leaves the module idle
    always_comb begin
        sel = CCA_OFF;
        if (!mode_reg[MODE_EQ_BIT] && !mode_reg[MODE_FLIP_BIT] && !mode_reg[MODE_PWM_BIT]
            && (mode_reg[MODE_RISE_BIT] || mode_reg[MODE_FALL_BIT])) begin
            sel = CCA_CAPT;
        end else if (mode_reg[MODE_CMP_BIT] && !mode_reg[MODE_RISE_BIT]
            && !mode_reg[MODE_FALL_BIT]) begin
            case (mode_reg[MODE_EQ_BIT:MODE_PWM_BIT])
                3'h4: sel = CCA_TIMER;
                3'h6: sel = CCA_HSO;
                3'h3: sel = CCA_FREQ;
                3'h1: begin
                    if (!mode_reg[MODE_IRQ_BIT]) begin
                        sel = mode_reg[MODE_WIDE_BIT] ? CCA_WIDE_MODULATOR_SELECT : CCA_PWM8;
                    end
                end
                default: sel = CCA_OFF;
            endcase
        end
    end

    // Pin level is already synchronised; this only remembers the last value
    assign rise = pin_level_i && !prev_reg;
    assign fall = !pin_level_i && prev_reg;
    assign cap_hit = (sel == CCA_CAPT)
        && ((mode_reg[MODE_RISE_BIT] && rise) || (mode_reg[MODE_FALL_BIT] && fall));
    assign match16 = (count_i == value_reg);
    assign match8 = (count_i[7:0] == value_reg[7:0]);
    always_comb begin
        case (sel)
            CCA_TIMER, CCA_HSO, CCA_WIDE_MODULATOR_SELECT: cmp_hit = match16;
            CCA_FREQ, CCA_PWM8: cmp_hit = match8;
            default: cmp_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= pin_level_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_reg <= MODE_RESET;
        end else if (mode_wr_i) begin
            mode_reg <= wdata_i;
        end
    end

    // Hardware capture or frequency reload wins over a software write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            value_reg <= VAL_RESET;
        end else if (cap_hit) begin
            value_reg <= count_i;
        end else if (sel == CCA_FREQ && match8) begin
            value_reg[7:0] <= value_reg[7:0] + value_reg[15:8];
        end else begin
            if (val_lo_wr_i) begin
                value_reg[7:0] <= wdata_i;
            end
            if (val_hi_wr_i) begin
                value_reg[15:8] <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= cap_hit || cmp_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= (sel == CCA_HSO) || (sel == CCA_FREQ)
                || (sel == CCA_PWM8) || (sel == CCA_WIDE_MODULATOR_SELECT);
            case (sel)
                CCA_HSO, CCA_FREQ: pin_reg <= pin_reg ^ cmp_hit;
                CCA_PWM8: pin_reg <= (count_i[7:0] >= value_reg[7:0]);
                CCA_WIDE_MODULATOR_SELECT: pin_reg <= (count_i >= value_reg);
                default: pin_reg <= 1'b0;
            endcase
        end
    end

    assign mode_o = mode_reg;
    assign value_o = value_reg;
    assign event_o = event_reg;
    assign pin_o = pin_reg;
    assign pin_oe_o = oe_reg;
endmodule

// [bench/cca_pin_model.sv]
// Pad model of the module pins seen from the board side
`timescale 1ns/1ps
module cca_pin_model #(
    parameter int SKEW_NS = 2
) (
    input wire logic [5:0] level_i,
    input wire logic [5:0] pin_o_i,
    input wire logic [5:0] pin_oe_i,
    output logic [5:0] pad_o
);
    // Skew keeps board edges off the sampling edge
    assign #(SKEW_NS) pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & level_i);
endmodule

// [bench/cca_top_chk.sv]
// Port checker of the capture/compare array
`timescale 1ns/1ps
module cca_top_chk #(
    parameter int NUM_MODULES = cca_pkg::MAX_MODULES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [cca_pkg::BYTE_W-1:0] sfr_wdata_i,
    input wire logic [cca_pkg::BYTE_W-1:0] sfr_rdata_o,
    input wire logic global_interrupt_enable_i,
    input wire logic array_interrupt_enable_i,
    input wire logic irq_o
);
    import cca_pkg::*;
    localparam logic [7:0] END_ADDR = ADDR_VAL_BASE + 8'(2 * NUM_MODULES);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ctrl_rd;
        sfr_rd_i && !sfr_wr_i && sfr_addr_i == ADDR_CTRL;
    endsequence
    sequence s_lo_rd;
        sfr_rd_i && !sfr_wr_i && sfr_addr_i == ADDR_CNT_LO;
    endsequence
    sequence s_run_wr(bit run);
        sfr_wr_i && sfr_addr_i == ADDR_CTRL && sfr_wdata_i[CTRL_RUN_BIT] == run
            ##1 !sfr_wr_i ##1 s_lo_rd ##1 !sfr_wr_i ##1 s_lo_rd;
    endsequence
    a_irq_global: assert property (!global_interrupt_enable_i |=> !irq_o)
        else $error("irq with global enable low");
    a_irq_array: assert property ($rose(irq_o) |-> $past(array_interrupt_enable_i))
        else $error("irq rose without array enable");
    a_unmapped_zero: assert property (sfr_rd_i && sfr_addr_i >= END_ADDR
        |=> sfr_rdata_o == RDATA_UNMAPPED) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    a_mode_readback: assert property (sfr_wr_i && sfr_addr_i == ADDR_MODE_BASE
        ##1 !sfr_wr_i ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == ADDR_MODE_BASE
        |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("mode readback wrong");
    a_run_counts: assert property (s_run_wr(1'b1)
        |=> 8'(sfr_rdata_o - $past(sfr_rdata_o)) == 8'h02) else $error("counter not running");
    a_stop_holds: assert property (s_run_wr(1'b0)
        |=> $stable(sfr_rdata_o)) else $error("stopped counter moved");
    a_flags_sticky: assert property (s_ctrl_rd ##2 s_ctrl_rd
        |=> ($past(sfr_rdata_o) & 8'hBF & ~sfr_rdata_o) == 8'h00) else $error("flag lost");
    a_run_readback: assert property (sfr_wr_i && sfr_addr_i == ADDR_CTRL ##2 s_ctrl_rd
        |=> sfr_rdata_o[CTRL_RUN_BIT] == $past(sfr_wdata_i[CTRL_RUN_BIT], 3))
        else $error("run bit readback wrong");
endmodule
bind cca_top cca_top_chk #(.NUM_MODULES(NUM_MODULES)) u_chk (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o),
    .global_interrupt_enable_i(global_interrupt_enable_i),
    .array_interrupt_enable_i(array_interrupt_enable_i));

// [bench/capture_compare_array_test.sv]
// Self-checking bench of the capture/compare array
`timescale 1ns/1ps
`define CCA_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module capture_compare_array_test;
    import cca_pkg::*;
    localparam logic [7:0] MB = ADDR_MODE_BASE;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic gie = 1'b1;
    logic aie = 1'b1;
    logic cie = 1'b0;
    logic [5:0] lvl = 6'h00;
    logic [5:0] pad;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [7:0] rdata;
    logic irq;
    logic [17:0] notes[$];
    logic [17:0] n;
    logic [7:0] got;
    logic rd_seen = 1'b0;
    logic snap = 1'b0;
    logic rise;
    logic fall;
    logic [31:0] seed = 32'h0001161F;
    string nm[4] = '{"rdata", "irq", "pin", "oe"};
    int num_errors = 0;
    int comparisons = 0;
    always #5 clk_i = ~clk_i;
    cca_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr_s),
        .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .global_interrupt_enable_i(gie), .array_interrupt_enable_i(aie),
        .counter_irq_enable_i(cie), .module_pin_i(pad), .module_pin_o(pin_out),
        .module_pin_oe_o(pin_oe), .irq_o(irq));
    cca_pin_model pins (.level_i(lvl), .pin_o_i(pin_out), .pin_oe_i(pin_oe), .pad_o(pad));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk_i);
        wr_s = 1'b0;
    endtask
    // Mask lets a read of the running counter pass unjudged
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(negedge clk_i);
        addr = a;
        rd_s = 1'b1;
        notes.push_back({2'd0, m, e & m});
        @(negedge clk_i);
        rd_s = 1'b0;
    endtask
    task automatic pk(input logic [1:0] k, input logic [7:0] e);
        @(negedge clk_i);
        snap = 1'b1;
        notes.push_back({k, 8'hFF, e});
        @(negedge clk_i);
        snap = 1'b0;
    endtask
    task automatic close_out;
        $display("num_errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Outputs are read before this edge's updates land
    always @(posedge clk_i) begin
        if (rd_seen || snap) begin
            n = notes.pop_front();
            case (n[17:16])
                2'd0: got = rdata;
                2'd1: got = {7'h00, irq};
                2'd2: got = {2'h0, pin_out};
                default: got = {2'h0, pin_oe};
            endcase
            `CCA_CHK(nm[n[17:16]], n[7:0], got & n[15:8])
        end
        rd_seen = rd_s;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        rd(ADDR_CTRL, CTRL_RESET);
        pk(2'd3, 8'h00);
        for (int j = 0; j < 6; j++) begin
            seed = xs(seed);
            wr(MB + 8'(j), seed[7:0]);
            rd(MB + 8'(j), seed[7:0]);
            wr(MB + 8'(j), MODE_RESET);
        end
        rd(8'h40, RDATA_UNMAPPED);
        for (int i = 0; i < 3; i++) begin
            rise = (i != 1);
            fall = (i != 0);
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_CNT_LO, 8'h34 + 8'(i));
            wr(ADDR_CNT_HI, 8'h12);
            wr(MB + 8'(i), {2'b00, rise, fall, 4'h1});
            lvl[i] = 1'b1;
            repeat (6) @(negedge clk_i);
            rd(ADDR_CTRL, 8'(rise) << i);
            pk(2'd1, 8'(rise));
            rd(ADDR_VAL_BASE + 8'(2 * i), rise ? 8'h34 + 8'(i) : 8'h00);
            rd(ADDR_VAL_BASE + 8'(2 * i + 1), rise ? 8'h12 : 8'h00);
            if (rise) begin
                gie = (i != 0);
                aie = (i != 2);
                pk(2'd1, 8'h00);
                gie = 1'b1;
                aie = 1'b1;
            end
            wr(ADDR_CTRL, 8'h00);
            lvl[i] = 1'b0;
            repeat (6) @(negedge clk_i);
            rd(ADDR_CTRL, 8'(fall) << i);
            wr(MB + 8'(i), MODE_RESET);
        end
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_VAL_BASE + 8'h06, 8'h10);
        wr(ADDR_VAL_BASE + 8'h08, 8'h10);
        wr(ADDR_VAL_BASE + 8'h0A, 8'h80);
        wr(MB + 8'h03, 8'h49);
        wr(MB + 8'h04, 8'h4C);
        wr(MB + 8'h05, 8'h42);
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CNT_LO, 8'h00, 8'h00);
        rd(ADDR_CNT_LO, 8'h00, 8'h00);
        repeat (40) @(negedge clk_i);
        wr(ADDR_CTRL, 8'h18);
        rd(ADDR_CNT_LO, 8'h00, 8'h00);
        rd(ADDR_CNT_LO, 8'h00, 8'h00);
        rd(ADDR_CTRL, 8'h18);
        pk(2'd1, 8'h01);
        pk(2'd2, 8'h10);
        wr(ADDR_CNT_LO, 8'h7F);
        pk(2'd2, 8'h10);
        wr(ADDR_CNT_LO, 8'h80);
        pk(2'd2, 8'h30);
        wr(ADDR_CNT_LO, 8'h7F);
        wr(MB + 8'h05, 8'hC2);
        wr(ADDR_CNT_HI, 8'h01);
        pk(2'd2, 8'h30);
        wr(MB + 8'h03, 8'h46);
        pk(2'd3, 8'h38);
        wr(ADDR_VAL_BASE + 8'h07, 8'h04);
        wr(ADDR_CNT_LO, 8'h10);
        pk(2'd2, 8'h38);
        rd(ADDR_VAL_BASE + 8'h06, 8'h14);
        rd(ADDR_VAL_BASE + 8'h07, 8'h04);
        for (int j = 3; j < 6; j++) wr(MB + 8'(j), MODE_RESET);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT_LO, 8'hFE);
        wr(ADDR_CNT_HI, 8'hFF);
        cie = 1'b1;
        wr(ADDR_CTRL, 8'h40);
        repeat (4) @(negedge clk_i);
        rd(ADDR_CTRL, 8'hC0);
        pk(2'd1, 8'h01);
        wr(ADDR_CTRL, 8'h80);
        rd(ADDR_CTRL, 8'h80);
        rd(ADDR_CTRL, 8'h80);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h00);
        pk(2'd1, 8'h00);
        close_out;
    end
endmodule
